//--- logic/cqa_pkg.sv
// shared constants and types of the compare and action-qualifier block
package cqa_pkg;
	localparam int unsigned CNT_W = 16;          // counter and register width
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_CMP_CTL  = 8'h07;
	localparam logic [7:0] IDX_CMP_A    = 8'h09;
	localparam logic [7:0] IDX_CMP_B    = 8'h0a;
	localparam logic [7:0] IDX_ACT_A    = 8'h0b;
	localparam logic [7:0] IDX_ACT_B    = 8'h0c;
	localparam logic [7:0] IDX_ONESHOT  = 8'h0d;
	localparam logic [7:0] IDX_CONT     = 8'h0e;
	localparam logic [7:0] IDX_STATUS   = 8'h0f;
	// compare_control fields
	localparam int unsigned CC_LOAD_A_LSB = 0;
	localparam int unsigned CC_LOAD_B_LSB = 2;
	localparam int unsigned CC_SHDW_A_BIT = 4;
	localparam int unsigned CC_SHDW_B_BIT = 6;
	localparam logic [15:0] CC_RESET     = 16'h0000;
	// oneshot_force fields
	localparam int unsigned OS_ACT_A_LSB = 0;
	localparam int unsigned OS_GO_A_BIT  = 2;
	localparam int unsigned OS_ACT_B_LSB = 3;
	localparam int unsigned OS_GO_B_BIT  = 5;
	localparam int unsigned OS_RLD_LSB   = 6;
	localparam logic [15:0] OS_RESET     = 16'h0000;
	// continuous_force fields
	localparam int unsigned CS_A_LSB     = 0;
	localparam int unsigned CS_B_LSB     = 2;
	localparam logic [15:0] CS_RESET     = 16'h0000;
	localparam logic [15:0] ACT_RESET    = 16'h0000;
	localparam logic [15:0] CMP_RESET    = 16'h0000;

	typedef enum logic [1:0] {
		ACT_NONE   = 2'b00,
		ACT_CLEAR  = 2'b01,
		ACT_SET    = 2'b10,
		ACT_TOGGLE = 2'b11
	} cqa_action_e;

	typedef enum logic [1:0] {
		MODE_UP     = 2'b00,
		MODE_DOWN   = 2'b01,
		MODE_UPDOWN = 2'b10,
		MODE_FROZEN = 2'b11
	} cqa_count_mode_e;

	// shadow load point, also used for the continuous force reload
	typedef enum logic [1:0] {
		LOAD_ZERO = 2'b00,
		LOAD_PRD  = 2'b01,
		LOAD_BOTH = 2'b10,
		LOAD_NOW  = 2'b11
	} cqa_load_e;

	typedef enum logic [1:0] {
		CS_OFF   = 2'b00,
		CS_LOW   = 2'b01,
		CS_HIGH  = 2'b10,
		CS_OFF2  = 2'b11
	} cqa_cont_e;

	typedef struct packed {
		logic [3:0]  rsvd;
		cqa_action_e cbd;
		cqa_action_e cbu;
		cqa_action_e cad;
		cqa_action_e cau;
		cqa_action_e prd;
		cqa_action_e zro;
	} cqa_act_ctl_s;

	typedef struct packed {
		logic zero;
		logic period;
		logic cmp_a;
		logic cmp_b;
	} cqa_events_s;
endpackage

//--- logic/cqa_compare_qualifier.sv
// compare events, shadowed compare values and action qualifier for two outputs
`timescale 1ns/10ps
module cqa_compare_qualifier #(
	parameter int unsigned CNT_W = cqa_pkg::CNT_W
) (
	input  wire logic              clk_sys_in,
	input  wire logic              rst_n_in,
	input  wire logic              hsel_in,
	input  wire logic [31:0]       haddr_in,
	input  wire logic [1:0]        htrans_in,
	input  wire logic              hwrite_in,
	input  wire logic [2:0]        hsize_in,
	input  wire logic [31:0]       hwdata_in,
	input  wire logic              hready_in,
	output logic      [31:0]       hrdata_out,
	output logic                   hreadyout_out,
	output logic                   hresp_out,
	input  wire logic              tb_tick_in,
	input  wire logic [CNT_W-1:0]  timebase_count_in,
	input  wire logic [CNT_W-1:0]  period_value_in,
	input  wire logic [1:0]        count_mode_in,
	input  wire logic              count_dir_up_in,
	output logic                   pwm_out_a_out,
	output logic                   pwm_out_b_out,
	output logic                   zero_match_event_out,
	output logic                   period_match_event_out,
	output logic                   compare_a_match_event_out,
	output logic                   compare_b_match_event_out
);
	localparam int unsigned PADW = 32 - CNT_W;

	// pick an action only if its event fired and it is enabled
	function automatic cqa_pkg::cqa_action_e pick(
		input cqa_pkg::cqa_action_e cur,
		input logic                 ev,
		input cqa_pkg::cqa_action_e a
	);
		pick = (ev && a != cqa_pkg::ACT_NONE) ? a : cur;
	endfunction

	// events applied lowest priority first, later ones override
	function automatic cqa_pkg::cqa_action_e resolve(
		input cqa_pkg::cqa_act_ctl_s c,
		input cqa_pkg::cqa_events_s  e,
		input logic [1:0]            mode,
		input logic                  up
	);
		cqa_pkg::cqa_action_e r;
		r = cqa_pkg::ACT_NONE;
		case (mode)
			cqa_pkg::MODE_UP: begin
				r = pick(r, e.zero, c.zro);
				r = pick(r, e.cmp_a, c.cau);
				r = pick(r, e.cmp_b, c.cbu);
				r = pick(r, e.period, c.prd);
			end
			cqa_pkg::MODE_DOWN: begin
				r = pick(r, e.period, c.prd);
				r = pick(r, e.cmp_a, c.cad);
				r = pick(r, e.cmp_b, c.cbd);
				r = pick(r, e.zero, c.zro);
			end
			default: begin
				if (up) begin
					r = pick(r, e.period, c.prd);
					r = pick(r, e.zero, c.zro);
					r = pick(r, e.cmp_a, c.cau);
					r = pick(r, e.cmp_b, c.cbu);
				end else begin
					r = pick(r, e.zero, c.zro);
					r = pick(r, e.period, c.prd);
					r = pick(r, e.cmp_a, c.cad);
					r = pick(r, e.cmp_b, c.cbd);
				end
			end
		endcase
		resolve = r;
	endfunction

	function automatic logic apply(
		input logic                 lvl,
		input cqa_pkg::cqa_action_e a
	);
		case (a)
			cqa_pkg::ACT_CLEAR:  apply = 1'b0;
			cqa_pkg::ACT_SET:    apply = 1'b1;
			cqa_pkg::ACT_TOGGLE: apply = ~lvl;
			default:             apply = lvl;
		endcase
	endfunction

	// bus slave state
	logic [31:0]       hrdata_reg;
	logic              hready_reg;
	logic              wr_pend_reg;
	logic [7:0]        wr_idx_reg;
	// block registers
	logic [15:0]       cmp_ctl_reg;
	logic [15:0]       act_ctl_reg [2];
	logic [15:0]       os_reg;
	logic [15:0]       cs_shd_reg;
	logic [15:0]       cs_act_reg;
	logic [CNT_W-1:0]  cmp_act_reg [2];
	logic [CNT_W-1:0]  cmp_shd_reg [2];
	logic [1:0]        os_pend_reg;
	logic [1:0]        pwm_reg;
	logic [3:0]        evt_reg;

	// address phase decode and write strobes
	wire               addr_ok   = hsel_in && htrans_in[1] && hready_in;
	wire  [7:0]        rd_idx    = haddr_in[9:2];
	wire               idx_hi_ok = (haddr_in[31:10] == 22'h000000);
	wire               wr_ok     = wr_pend_reg;
	wire  [15:0]       wdat      = hwdata_in[15:0];
	wire               wr_cc     = wr_ok && wr_idx_reg == cqa_pkg::IDX_CMP_CTL;
	wire               wr_os     = wr_ok && wr_idx_reg == cqa_pkg::IDX_ONESHOT;
	wire               wr_cs     = wr_ok && wr_idx_reg == cqa_pkg::IDX_CONT;
	wire  [1:0]        wr_cmp;
	wire  [1:0]        wr_act;
	wire  [1:0]        shdw_off;
	wire  [1:0]        ld_sel    [2];
	assign wr_cmp[0] = wr_ok && wr_idx_reg == cqa_pkg::IDX_CMP_A;
	assign wr_cmp[1] = wr_ok && wr_idx_reg == cqa_pkg::IDX_CMP_B;
	assign wr_act[0] = wr_ok && wr_idx_reg == cqa_pkg::IDX_ACT_A;
	assign wr_act[1] = wr_ok && wr_idx_reg == cqa_pkg::IDX_ACT_B;
	assign shdw_off[0] = cmp_ctl_reg[cqa_pkg::CC_SHDW_A_BIT];
	assign shdw_off[1] = cmp_ctl_reg[cqa_pkg::CC_SHDW_B_BIT];
	assign ld_sel[0] = cmp_ctl_reg[cqa_pkg::CC_LOAD_A_LSB +: 2];
	assign ld_sel[1] = cmp_ctl_reg[cqa_pkg::CC_LOAD_B_LSB +: 2];

	// compare reads follow the same copy that writes reach
	wire  [CNT_W-1:0]  cmp_view_a = shdw_off[0] ? cmp_act_reg[0]
	                                            : cmp_shd_reg[0];
	wire  [CNT_W-1:0]  cmp_view_b = shdw_off[1] ? cmp_act_reg[1]
	                                            : cmp_shd_reg[1];
	// one-shot go bits are write-only and read as zero
	wire  [15:0]       os_view = os_reg & ~(16'h0001 << cqa_pkg::OS_GO_A_BIT)
	                                    & ~(16'h0001 << cqa_pkg::OS_GO_B_BIT);
	logic [31:0]       rd_mux;
	always_comb begin
		rd_mux = 32'h00000000;
		if (idx_hi_ok) begin
			case (rd_idx)
				cqa_pkg::IDX_CMP_CTL: rd_mux = {16'h0000, cmp_ctl_reg};
				cqa_pkg::IDX_CMP_A:   rd_mux = {{PADW{1'b0}}, cmp_view_a};
				cqa_pkg::IDX_CMP_B:   rd_mux = {{PADW{1'b0}}, cmp_view_b};
				cqa_pkg::IDX_ACT_A:   rd_mux = {16'h0000, act_ctl_reg[0]};
				cqa_pkg::IDX_ACT_B:   rd_mux = {16'h0000, act_ctl_reg[1]};
				cqa_pkg::IDX_ONESHOT: rd_mux = {16'h0000, os_view};
				cqa_pkg::IDX_CONT:    rd_mux = {16'h0000, cs_shd_reg};
				cqa_pkg::IDX_STATUS:  rd_mux = {28'h0000000, os_pend_reg,
				                                pwm_reg};
				default:              rd_mux = 32'h00000000;
			endcase
		end
	end

	// ahb-lite slave: zero wait states, read data captured in address phase
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			hrdata_reg  <= 32'h00000000;
			hready_reg  <= 1'b0;
			wr_pend_reg <= 1'b0;
			wr_idx_reg  <= 8'h00;
		end else begin
			hready_reg  <= 1'b1;
			wr_pend_reg <= addr_ok && hwrite_in && idx_hi_ok;
			wr_idx_reg  <= rd_idx;
			if (addr_ok && !hwrite_in) begin
				hrdata_reg <= rd_mux;
			end
		end
	end

	// event detection; frozen counter stays silent since it would repeat
	wire               run     = tb_tick_in &&
	                             count_mode_in != cqa_pkg::MODE_FROZEN;
	wire               dir_up  = (count_mode_in == cqa_pkg::MODE_UP) ||
	                             (count_mode_in == cqa_pkg::MODE_UPDOWN &&
	                              count_dir_up_in);
	cqa_pkg::cqa_events_s ev;
	assign ev.zero   = run && timebase_count_in == '0;
	assign ev.period = run && timebase_count_in == period_value_in;
	// only active copies are compared; a count that never reaches the value
	// above the period gives no event, and a skipped count after a sync
	// jump is simply missed
	// up mode: a value above the period is gated, not left to the counter
	wire  [1:0]        cmp_ok;
	assign cmp_ok[0] = count_mode_in != cqa_pkg::MODE_UP ||
	                   cmp_act_reg[0] <= period_value_in;
	assign cmp_ok[1] = count_mode_in != cqa_pkg::MODE_UP ||
	                   cmp_act_reg[1] <= period_value_in;
	// equality: one event per pass, two in up-down unless at an end point
	assign ev.cmp_a  = run && cmp_ok[0] &&
	                   timebase_count_in == cmp_act_reg[0];
	assign ev.cmp_b  = run && cmp_ok[1] &&
	                   timebase_count_in == cmp_act_reg[1];

	// continuous force active-copy reload point
	wire  [1:0]        cs_rld = os_reg[cqa_pkg::OS_RLD_LSB +: 2];
	wire               cs_load = (cs_rld == cqa_pkg::LOAD_NOW) ||
	                             (ev.zero && cs_rld != cqa_pkg::LOAD_PRD) ||
	                             (ev.period && cs_rld != cqa_pkg::LOAD_ZERO);

	// shared control registers
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cmp_ctl_reg <= cqa_pkg::CC_RESET;
			os_reg      <= cqa_pkg::OS_RESET;
			cs_shd_reg  <= cqa_pkg::CS_RESET;
			cs_act_reg  <= cqa_pkg::CS_RESET;
			evt_reg     <= 4'h0;
		end else begin
			if (wr_cc) begin
				cmp_ctl_reg <= wdat;
			end
			if (wr_os) begin
				os_reg <= wdat;
			end
			if (wr_cs) begin
				cs_shd_reg <= wdat;
			end
			if (cs_load) begin
				cs_act_reg <= cs_shd_reg;
			end
			// events go out even when their action is none
			evt_reg <= {ev.cmp_b, ev.cmp_a, ev.period, ev.zero};
		end
	end

	// per-channel compare, shadow, qualifier and output
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_chan
			cqa_pkg::cqa_action_e aq_act;
			cqa_pkg::cqa_action_e os_act;
			cqa_pkg::cqa_cont_e   cs_sel;
			logic                 os_go;
			logic                 shd_load;
			logic                 lvl_next;
			logic                 cs_on;
			// each output resolves its own configured set of events
			assign aq_act = resolve(act_ctl_reg[ch], ev, count_mode_in,
			                        dir_up);
			assign os_act = cqa_pkg::cqa_action_e'(ch == 0
			              ? os_reg[cqa_pkg::OS_ACT_A_LSB +: 2]
			              : os_reg[cqa_pkg::OS_ACT_B_LSB +: 2]);
			assign os_go  = wr_os && (ch == 0 ? wdat[cqa_pkg::OS_GO_A_BIT]
			                                  : wdat[cqa_pkg::OS_GO_B_BIT]);
			assign cs_sel = cqa_pkg::cqa_cont_e'(ch == 0
			              ? cs_act_reg[cqa_pkg::CS_A_LSB +: 2]
			              : cs_act_reg[cqa_pkg::CS_B_LSB +: 2]);
			assign cs_on  = cs_sel == cqa_pkg::CS_LOW ||
			                cs_sel == cqa_pkg::CS_HIGH;
			assign shd_load = !shdw_off[ch] && ld_sel[ch] != cqa_pkg::LOAD_NOW &&
			                  ((ev.zero && ld_sel[ch] != cqa_pkg::LOAD_PRD) ||
			                   (ev.period &&
			                    ld_sel[ch] != cqa_pkg::LOAD_ZERO));
			// force beats one-shot beats qualified event
			always_comb begin
				if (cs_on) begin
					lvl_next = (cs_sel == cqa_pkg::CS_HIGH);
				end else if (os_pend_reg[ch]) begin
					lvl_next = apply(pwm_reg[ch], os_act);
				end else begin
					lvl_next = apply(pwm_reg[ch], aq_act);
				end
			end

			// compare copies; a write and a load in one cycle: load takes the
			// old shadow, the new word waits for the next load point
			always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					cmp_act_reg[ch] <= cqa_pkg::CMP_RESET[CNT_W-1:0];
					cmp_shd_reg[ch] <= cqa_pkg::CMP_RESET[CNT_W-1:0];
				end else begin
					if (wr_cmp[ch] && !shdw_off[ch]) begin
						cmp_shd_reg[ch] <= wdat[CNT_W-1:0];
					end
					if (wr_cmp[ch] && shdw_off[ch]) begin
						cmp_act_reg[ch] <= wdat[CNT_W-1:0];
					end else if (shd_load) begin
						cmp_act_reg[ch] <= cmp_shd_reg[ch];
					end
				end
			end

			// action control, one-shot request and output level
			always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					act_ctl_reg[ch] <= cqa_pkg::ACT_RESET;
					os_pend_reg[ch] <= 1'b0;
					pwm_reg[ch]     <= 1'b0;
				end else begin
					if (wr_act[ch]) begin
						act_ctl_reg[ch] <= wdat;
					end
					// a new request in the serving cycle is kept, not lost
					os_pend_reg[ch] <= os_go;
					pwm_reg[ch]     <= lvl_next;
				end
			end
		end
	endgenerate

	// outputs straight from flip-flops, except hresp_out tied to zero
	assign hrdata_out                = hrdata_reg;
	assign hreadyout_out             = hready_reg;
	assign hresp_out                 = 1'b0;
	assign pwm_out_a_out             = pwm_reg[0];
	assign pwm_out_b_out             = pwm_reg[1];
	assign zero_match_event_out      = evt_reg[0];
	assign period_match_event_out    = evt_reg[1];
	assign compare_a_match_event_out = evt_reg[2];
	assign compare_b_match_event_out = evt_reg[3];

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);

	chk_compare_value_a_event_out: assert property (
		(run && timebase_count_in == cmp_act_reg[0] &&
		 (count_mode_in != cqa_pkg::MODE_UP ||
		  cmp_act_reg[0] <= period_value_in)) |=>
		compare_a_match_event_out)
		else $error("compare a match not reported");
	chk_above_period: assert property (
		(run && count_mode_in == cqa_pkg::MODE_UP &&
		 cmp_act_reg[0] > period_value_in) |=> !compare_a_match_event_out)
		else $error("compare a above period produced an event");
	chk_event_needs_tick: assert property (
		!tb_tick_in |=> !(compare_a_match_event_out ||
		compare_b_match_event_out || zero_match_event_out))
		else $error("event without a timebase tick");
	chk_updown_once: assert property (
		(run && count_mode_in == cqa_pkg::MODE_UPDOWN &&
		 cmp_act_reg[1] == '0 && timebase_count_in == '0) |=>
		(compare_b_match_event_out && zero_match_event_out))
		else $error("zero compare not reported with zero match");
	chk_shadow_load_a: assert property (
		(g_chan[0].shd_load && !wr_cmp[0]) |=>
		cmp_act_reg[0] == $past(cmp_shd_reg[0]))
		else $error("shadow a not loaded at load point");
	chk_shadow_hold_a: assert property (
		(!g_chan[0].shd_load && !wr_cmp[0]) |=> $stable(cmp_act_reg[0]))
		else $error("active a changed outside load point");
	chk_immediate_wr: assert property (
		(wr_cmp[1] && shdw_off[1]) |=>
		cmp_act_reg[1] == $past(wdat[CNT_W-1:0]))
		else $error("immediate write missed active b");
	chk_cont_force: assert property (
		(g_chan[0].cs_sel == cqa_pkg::CS_LOW) |=> !pwm_out_a_out)
		else $error("continuous low force not applied");
	chk_cont_high: assert property (
		(g_chan[0].cs_sel == cqa_pkg::CS_HIGH) |=> pwm_out_a_out)
		else $error("continuous high force not applied");
	chk_toggle_flip: assert property (
		(!g_chan[1].cs_on && !os_pend_reg[1] &&
		 g_chan[1].aq_act == cqa_pkg::ACT_TOGGLE) |=>
		pwm_out_b_out != $past(pwm_out_b_out))
		else $error("toggle did not invert output b");
	chk_no_action: assert property (
		(!g_chan[0].cs_on && !os_pend_reg[0] && act_ctl_reg[0] == '0)
		|=> $stable(pwm_out_a_out))
		else $error("output a moved with no action set");
	chk_sw_wins: assert property (
		(!g_chan[0].cs_on && os_pend_reg[0] &&
		 g_chan[0].os_act == cqa_pkg::ACT_SET) |=> pwm_out_a_out)
		else $error("one-shot set lost to an event");
endmodule // cqa_compare_qualifier

//--- testbench/cqa_deadband_model.sv
// dead-band stage model that counts rising edges of output a
`timescale 1ns/10ps
module cqa_deadband_model (
	input  wire logic       clk_sys_in,
	input  wire logic       rst_n_in,
	input  wire logic       pwm_a_in,
	output logic      [7:0] rises_a_out
);
	logic pwm_a_reg;

	// the stage only reacts to edges, so a rise the bench never saw shows here
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pwm_a_reg   <= 1'b0;
			rises_a_out <= 8'h00;
		end else begin
			pwm_a_reg <= pwm_a_in;
			if (pwm_a_in && !pwm_a_reg) begin
				rises_a_out <= rises_a_out + 8'h01;
			end
		end
	end
endmodule // cqa_deadband_model

//--- testbench/tb_cqa_compare_qualifier.sv
// testbench for the compare and action-qualifier block
`timescale 1ns/10ps
module tb_cqa_compare_qualifier;
	logic        clk_sys_in = 1'b0;
	logic        rst_n_in   = 1'b0;
	logic        hsel       = 1'b0;
	logic [31:0] haddr      = 32'h0;
	logic [1:0]  htrans     = 2'h0;
	logic        hwrite     = 1'b0;
	logic [31:0] hwdata     = 32'h0;
	logic [31:0] hrdata;
	logic        hready;
	logic        hresp;
	logic        tick       = 1'b0;
	logic [15:0] cnt        = 16'h0;
	logic [15:0] prd        = 16'h000a;
	logic [1:0]  mode       = 2'h0;
	logic        dir_up     = 1'b1;
	logic        pa, pb, ez, ep, eca, ecb;
	logic [7:0]  rises_a;
	logic [3:0]  ev;
	logic [31:0] rd;
	logic        exp_a      = 1'b0;
	int          error_cnt  = 0;
	int          n_compared = 0;
	int          exp_rises  = 0;
	logic [7:0]  idx_list [7] = '{cqa_pkg::IDX_CMP_CTL, cqa_pkg::IDX_CMP_A,
		cqa_pkg::IDX_CMP_B, cqa_pkg::IDX_ACT_A, cqa_pkg::IDX_ACT_B,
		cqa_pkg::IDX_CONT, 8'h20};

	always #50 clk_sys_in = ~clk_sys_in;

	cqa_compare_qualifier DUT (
		.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .hsel_in(hsel),
		.haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
		.hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
		.hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
		.tb_tick_in(tick), .timebase_count_in(cnt), .period_value_in(prd),
		.count_mode_in(mode), .count_dir_up_in(dir_up),
		.pwm_out_a_out(pa), .pwm_out_b_out(pb),
		.zero_match_event_out(ez), .period_match_event_out(ep),
		.compare_a_match_event_out(eca), .compare_b_match_event_out(ecb));

	cqa_deadband_model model (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
		.pwm_a_in(pa), .rises_a_out(rises_a));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// bounded wait for hready high at a rising edge
	task automatic wait_ready();
		int i;
		i = 0;
		do begin
			@(posedge clk_sys_in);
			i++;
		end while (hready !== 1'b1 && i < 50);
		if (hready !== 1'b1) begin
			error_cnt++;
			summarize();
		end
	endtask

	// one single-word transfer; read data lands in rd
	task automatic ahb(input logic [7:0] idx, input logic wr,
		input logic [15:0] wd);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= {22'h0, idx, 2'b00};
		hwrite <= wr;
		wait_ready();
		htrans <= 2'b00;
		hsel   <= 1'b0;
		hwdata <= {16'h0, wd};
		wait_ready();
		rd = hrdata;
	endtask

	// one time-base tick, then compare the event pulses {zero,prd,a,b}
	task automatic tke(input logic [15:0] c, input logic [1:0] m,
		input logic up, input logic [3:0] e);
		tick   <= 1'b1;
		cnt    <= c;
		mode   <= m;
		dir_up <= up;
		@(posedge clk_sys_in);
		tick <= 1'b0;
		#1;
		ev = {ez, ep, eca, ecb};
		check({28'h0, ev}, {28'h0, e});
		@(posedge clk_sys_in);
	endtask

	// levels are looked at two edges on so a software write has landed
	task automatic expect_pwm(input logic a, input logic b);
		if (a && !exp_a) begin
			exp_rises++;
		end
		exp_a = a;
		repeat (2) @(posedge clk_sys_in);
		#1;
		check({30'h0, pa, pb}, {30'h0, a, b});
	endtask

	initial begin
		repeat (5) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		repeat (2) @(posedge clk_sys_in);
		foreach (idx_list[i]) begin
			ahb(idx_list[i], 1'b0, 16'h0);
			check(rd, 32'h0);
		end
		check({31'h0, hresp}, 32'h0);
		// reset actions are none: events still pulse, levels hold
		tke(16'h0, cqa_pkg::MODE_UP, 1'b1, 4'hb);
		expect_pwm(1'b0, 1'b0);
		// immediate load on both channels
		ahb(cqa_pkg::IDX_CMP_CTL, 1'b1, 16'h0050);
		ahb(cqa_pkg::IDX_CMP_A, 1'b1, 16'h0005);
		ahb(cqa_pkg::IDX_CMP_B, 1'b1, 16'h0007);
		ahb(cqa_pkg::IDX_CMP_A, 1'b0, 16'h0);
		check(rd, 32'h5);
		// a: zero clear, cau set, cad clear, cbu toggle; b: cbu toggle
		ahb(cqa_pkg::IDX_ACT_A, 1'b1, 16'h0361);
		ahb(cqa_pkg::IDX_ACT_B, 1'b1, 16'h0300);
		tke(16'h5, cqa_pkg::MODE_UP, 1'b1, 4'h2);
		expect_pwm(1'b1, 1'b0);
		tke(16'h5, cqa_pkg::MODE_DOWN, 1'b0, 4'h2);
		expect_pwm(1'b0, 1'b0);
		tke(16'h7, cqa_pkg::MODE_UP, 1'b1, 4'h1);
		expect_pwm(1'b1, 1'b1);
		tke(16'h7, cqa_pkg::MODE_UP, 1'b1, 4'h1);
		expect_pwm(1'b0, 1'b0);
		tke(16'h5, cqa_pkg::MODE_UPDOWN, 1'b1, 4'h2);
		expect_pwm(1'b1, 1'b0);
		tke(16'h5, cqa_pkg::MODE_UPDOWN, 1'b0, 4'h2);
		expect_pwm(1'b0, 1'b0);
		// coincident compares: b's event is later, so it wins
		ahb(cqa_pkg::IDX_ACT_A, 1'b1, 16'h0b61);
		ahb(cqa_pkg::IDX_CMP_B, 1'b1, 16'h0005);
		tke(16'h5, cqa_pkg::MODE_DOWN, 1'b0, 4'h3);
		expect_pwm(1'b1, 1'b0);
		tke(16'h5, cqa_pkg::MODE_UP, 1'b1, 4'h3);
		expect_pwm(1'b0, 1'b1);
		ahb(cqa_pkg::IDX_CMP_A, 1'b1, 16'h000c);
		tke(16'hc, cqa_pkg::MODE_UP, 1'b1, 4'h0);
		// a shadowed, loaded at zero, then at period
		ahb(cqa_pkg::IDX_CMP_CTL, 1'b1, 16'h0040);
		ahb(cqa_pkg::IDX_CMP_A, 1'b1, 16'h0009);
		ahb(cqa_pkg::IDX_CMP_A, 1'b0, 16'h0);
		check(rd, 32'h9);
		tke(16'h9, cqa_pkg::MODE_UP, 1'b1, 4'h0);
		tke(16'h0, cqa_pkg::MODE_UP, 1'b1, 4'h8);
		expect_pwm(1'b0, 1'b1);
		tke(16'h9, cqa_pkg::MODE_UP, 1'b1, 4'h2);
		expect_pwm(1'b1, 1'b1);
		ahb(cqa_pkg::IDX_CMP_CTL, 1'b1, 16'h0041);
		ahb(cqa_pkg::IDX_CMP_A, 1'b1, 16'h0003);
		tke(16'h0, cqa_pkg::MODE_UP, 1'b1, 4'h8);
		expect_pwm(1'b0, 1'b1);
		tke(16'h3, cqa_pkg::MODE_UP, 1'b1, 4'h0);
		tke(16'ha, cqa_pkg::MODE_UP, 1'b1, 4'h4);
		tke(16'h3, cqa_pkg::MODE_UP, 1'b1, 4'h2);
		expect_pwm(1'b1, 1'b1);
		tke(16'h0, cqa_pkg::MODE_UP, 1'b1, 4'h8);
		expect_pwm(1'b0, 1'b1);
		// continuous force high waits for the zero reload, then beats events
		ahb(cqa_pkg::IDX_CONT, 1'b1, 16'h0002);
		expect_pwm(1'b0, 1'b1);
		tke(16'h0, cqa_pkg::MODE_UP, 1'b1, 4'h8);
		expect_pwm(1'b1, 1'b1);
		ahb(cqa_pkg::IDX_ONESHOT, 1'b1, 16'h0005);
		expect_pwm(1'b1, 1'b1);
		ahb(cqa_pkg::IDX_ONESHOT, 1'b0, 16'h0);
		check(rd, 32'h1);
		ahb(cqa_pkg::IDX_CONT, 1'b1, 16'h0000);
		tke(16'h0, cqa_pkg::MODE_UP, 1'b1, 4'h8);
		// the force still governs the reload tick itself
		expect_pwm(1'b1, 1'b1);
		tke(16'h0, cqa_pkg::MODE_UP, 1'b1, 4'h8);
		expect_pwm(1'b0, 1'b1);
		// one-shot set on a, then one-shot toggle on b
		ahb(cqa_pkg::IDX_ONESHOT, 1'b1, 16'h0006);
		expect_pwm(1'b1, 1'b1);
		ahb(cqa_pkg::IDX_ONESHOT, 1'b1, 16'h0038);
		expect_pwm(1'b1, 1'b0);
		// up-down compare b at zero fires once, together with zero
		ahb(cqa_pkg::IDX_CMP_B, 1'b1, 16'h0000);
		tke(16'h0, cqa_pkg::MODE_UPDOWN, 1'b0, 4'h9);
		expect_pwm(1'b1, 1'b0);
		check({24'h0, rises_a}, exp_rises);
		summarize();
	end
endmodule // tb_cqa_compare_qualifier
